// file: core/fls_pkg.sv
// package: timing, the read-array command code and states for the flash bus host
package fls_pkg;

  // clock and data path
  localparam int CLK_PERIOD_NS = 20;
  localparam int DATA_W        = 16;
  localparam int TMR_W         = 8;

  // pin timing in ns (plain defaults, adjust to the fitted part)
  localparam int RESET_LOW_PULSE_TIME_NS  = 100;
  localparam int WAKEUP_TO_DATA_TIME_NS   = 400;
  localparam int RESET_TO_COMMAND_TIME_NS = 1000;
  localparam int READ_ACCESS_TIME_NS      = 100;
  localparam int ADDR_SETUP_TIME_NS       = 10;
  localparam int WE_PULSE_TIME_NS         = 50;
  localparam int DATA_HOLD_TIME_NS        = 10;
  localparam int BUS_GAP_TIME_NS          = 20;

  // least time in ns to whole cycles, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int RESET_LOW_CYC = cyc_up(RESET_LOW_PULSE_TIME_NS);
  localparam int WAKEUP_CYC    = cyc_up(WAKEUP_TO_DATA_TIME_NS);
  localparam int RECOVERY_CYC  = cyc_up(RESET_TO_COMMAND_TIME_NS);
  localparam int WAKE_CYC      = (WAKEUP_CYC > RECOVERY_CYC) ? WAKEUP_CYC : RECOVERY_CYC;
  localparam int ACCESS_CYC    = cyc_up(READ_ACCESS_TIME_NS);
  localparam int SETUP_CYC     = cyc_up(ADDR_SETUP_TIME_NS);
  localparam int PULSE_CYC     = cyc_up(WE_PULSE_TIME_NS);
  localparam int HOLD_CYC      = cyc_up(DATA_HOLD_TIME_NS);
  localparam int GAP_CYC       = cyc_up(BUS_GAP_TIME_NS);

  // command byte that returns the device to array reads
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;

  // bus sequencer states
  typedef enum logic [8:0] {
    ST_PD_START  = 9'h001,
    ST_PD_HOLD   = 9'h002,
    ST_WAKE      = 9'h004,
    ST_IDLE      = 9'h008,
    ST_WR_SETUP  = 9'h010,
    ST_WR_PULSE  = 9'h020,
    ST_WR_HOLD   = 9'h040,
    ST_RD_ACCESS = 9'h080,
    ST_GAP       = 9'h100
  } fls_state_t;

endpackage : fls_pkg

// file: core/fls_tmr_if.sv
// interface: load and done signals between sequencer and cycle timer
`timescale 1ns/1ps
interface fls_tmr_if #(parameter int W = 8);
  logic         load;
  logic [W-1:0] value;
  logic         done;
  modport ctl (output load, output value, input done);
  modport cnt (input load, input value, output done);
endinterface : fls_tmr_if

// file: core/fls_timer.sv
// module: down counter that times each phase of a bus cycle
`timescale 1ns/1ps
module fls_timer #(
  parameter int W = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  fls_tmr_if.cnt    t
);
  import fls_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } fls_tmr_st_t;

  fls_tmr_st_t r_reg;
  fls_tmr_st_t r_next;

  // load restarts the count, otherwise count down to zero and stay
  always_comb begin
    r_next = r_reg;
    if (t.load) begin
      r_next.cnt = t.value;
    end else if (r_reg.cnt != '0) begin
      r_next.cnt = r_reg.cnt - W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign t.done = (r_reg.cnt == '0);

endmodule : fls_timer

// file: core/fls_host.sv
// module: host-side bus controller driving an asynchronous parallel flash
`timescale 1ns/1ps
module fls_host #(
  parameter int ADDR_W = 22
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  // user side
  input  wire logic                      powerdown_req,
  input  wire logic                      wide_mode,
  input  wire logic                      req_valid,
  input  wire logic                      req_write,
  input  wire logic [ADDR_W-1:0]         req_addr,
  input  wire logic [fls_pkg::DATA_W-1:0] req_wdata,
  output logic                           req_ready,
  output logic                           rsp_valid,
  output logic [fls_pkg::DATA_W-1:0]     rsp_rdata,
  output logic                           array_mode,
  output logic                           flash_busy,
  // flash pins
  output logic                           chip_select_a_n,
  output logic                           chip_select_b_n,
  output logic                           output_enable_n,
  output logic                           write_enable_n,
  output logic                           reset_powerdown_n,
  output logic                           width_select,
  output logic [ADDR_W-1:0]              flash_addr,
  output logic [fls_pkg::DATA_W-1:0]     dq_out,
  output logic                           dq_oe,
  input  wire logic [fls_pkg::DATA_W-1:0] dq_in,
  input  wire logic                      ready_busy_level
);
  import fls_pkg::*;

  typedef struct packed {
    fls_state_t          state;
    logic                cs_n;
    logic                oe_n;
    logic                we_n;
    logic                rp_n;
    logic                wide;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq_o;
    logic                dq_oe;
    logic [DATA_W-1:0]   rdata;
    logic                rsp_valid;
    logic                req_ready;
    logic                array_mode;
    logic                busy;
  } fls_host_st_t;

  // reset image: flash held in power-down, bus idle, data released
  localparam fls_host_st_t RST_ST = '{
    state: ST_PD_START, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rp_n: 1'b0,
    wide: 1'b0, addr: '0, dq_o: '0, dq_oe: 1'b0, rdata: '0,
    rsp_valid: 1'b0, req_ready: 1'b0, array_mode: 1'b0, busy: 1'b0
  };

  fls_host_st_t r_reg;
  fls_host_st_t r_next;

  fls_tmr_if #(.W(TMR_W)) tmr ();

  fls_timer #(
    .W (TMR_W)
  ) u_timer (
    .clk (clk),
    .rst (rst),
    .t   (tmr.cnt)
  );

  //////////////////////////////////////////////////////////////////////////
  // sequencer: power-down, wake-up, read and command-write cycles
  always_comb begin
    r_next           = r_reg;
    tmr.load         = 1'b0;
    tmr.value        = '0;
    r_next.rsp_valid = 1'b0;
    r_next.busy      = ~ready_busy_level;
    if (powerdown_req && (r_reg.state != ST_PD_START) && (r_reg.state != ST_PD_HOLD)) begin
      // abort whatever runs and drop into power-down
      r_next.state     = ST_PD_START;
      r_next.rp_n      = 1'b0;
      r_next.cs_n      = 1'b1;
      r_next.oe_n      = 1'b1;
      r_next.we_n      = 1'b1;
      r_next.dq_oe     = 1'b0;
      r_next.req_ready = 1'b0;
    end else begin
      unique case (r_reg.state)
        ST_PD_START: begin
          // reset pin is low here; start the least pulse time
          r_next.rp_n = 1'b0;
          tmr.load    = 1'b1;
          tmr.value   = TMR_W'(RESET_LOW_CYC - 1);
          r_next.state = ST_PD_HOLD;
        end
        ST_PD_HOLD: begin
          if (tmr.done && !powerdown_req) begin
            r_next.rp_n  = 1'b1;
            tmr.load     = 1'b1;
            tmr.value    = TMR_W'(WAKE_CYC - 1);
            r_next.state = ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (tmr.done) begin
            r_next.state      = ST_IDLE;
            r_next.req_ready  = 1'b1;
            r_next.array_mode = 1'b1;
          end
        end
        ST_IDLE: begin
          r_next.wide = wide_mode;
          if (req_valid && r_reg.req_ready) begin
            r_next.req_ready = 1'b0;
            r_next.addr      = req_addr;
            r_next.cs_n      = 1'b0;
            tmr.load         = 1'b1;
            if (req_write) begin
              // data driven while output enable stays high
              r_next.dq_o  = req_wdata;
              r_next.dq_oe = 1'b1;
              tmr.value    = TMR_W'(SETUP_CYC - 1);
              r_next.state = ST_WR_SETUP;
            end else begin
              r_next.oe_n  = 1'b0;
              tmr.value    = TMR_W'(ACCESS_CYC - 1);
              r_next.state = ST_RD_ACCESS;
            end
          end
        end
        ST_WR_SETUP: begin
          if (tmr.done) begin
            r_next.we_n  = 1'b0;
            tmr.load     = 1'b1;
            tmr.value    = TMR_W'(PULSE_CYC - 1);
            r_next.state = ST_WR_PULSE;
          end
        end
        ST_WR_PULSE: begin
          if (tmr.done) begin
            // write enable rises first so it is the latching edge
            r_next.we_n  = 1'b1;
            tmr.load     = 1'b1;
            tmr.value    = TMR_W'(HOLD_CYC - 1);
            r_next.state = ST_WR_HOLD;
          end
        end
        ST_WR_HOLD: begin
          if (tmr.done) begin
            r_next.cs_n       = 1'b1;
            r_next.dq_oe      = 1'b0;
            r_next.array_mode = (r_reg.dq_o[7:0] == CMD_READ_ARRAY);
            tmr.load          = 1'b1;
            tmr.value         = TMR_W'(GAP_CYC - 1);
            r_next.state      = ST_GAP;
          end
        end
        ST_RD_ACCESS: begin
          if (tmr.done) begin
            // narrow mode reads only the low byte
            r_next.rdata     = r_reg.wide ? dq_in : {8'h00, dq_in[7:0]};
            r_next.rsp_valid = 1'b1;
            r_next.oe_n      = 1'b1;
            r_next.cs_n      = 1'b1;
            tmr.load         = 1'b1;
            tmr.value        = TMR_W'(GAP_CYC - 1);
            r_next.state     = ST_GAP;
          end
        end
        ST_GAP: begin
          // bus idle between cycles so the device floats its outputs
          if (tmr.done) begin
            r_next.req_ready = 1'b1;
            r_next.state     = ST_IDLE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register; system reset also resets the flash
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= RST_ST;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign chip_select_a_n   = r_reg.cs_n;
  assign chip_select_b_n   = r_reg.cs_n;
  assign output_enable_n   = r_reg.oe_n;
  assign write_enable_n    = r_reg.we_n;
  assign reset_powerdown_n = r_reg.rp_n;
  assign width_select      = r_reg.wide;
  assign flash_addr        = r_reg.addr;
  assign dq_out            = r_reg.dq_o;
  assign dq_oe             = r_reg.dq_oe;
  assign req_ready         = r_reg.req_ready;
  assign rsp_valid         = r_reg.rsp_valid;
  assign rsp_rdata         = r_reg.rdata;
  assign array_mode        = r_reg.array_mode;
  assign flash_busy        = r_reg.busy;

endmodule : fls_host

// file: verif/fls_flash_model.sv
// model: flash device pins seen from the host side
`timescale 1ns/1ps
module fls_flash_model #(
  parameter int          BUSY_CYC   = 40,
  parameter logic [15:0] MAKER_CODE = 16'h00C3, // arbitrary identifier value
  parameter logic [15:0] PART_CODE  = 16'h3C11  // arbitrary identifier value
) (
  input  wire logic        clk,
  input  wire logic        chip_select_a_n,
  input  wire logic        chip_select_b_n,
  input  wire logic        output_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic        reset_powerdown_n,
  input  wire logic        width_select,
  input  wire logic [21:0] flash_addr,
  input  wire logic [15:0] dq_bus,
  output logic      [15:0] dq_drive,
  output logic             ready_busy_level
);
  logic [7:0]  mode_reg;
  logic [7:0]  prev_reg;
  logic        we_reg;
  int          busy_cnt;
  logic        sel;
  logic [15:0] arr;
  logic [15:0] id_word;
  // selected only with both selects low and reset high
  assign sel = !chip_select_a_n && !chip_select_b_n && reset_powerdown_n;
  assign arr = flash_addr[15:0] ^ 16'h5A5A;
  // identifier words: maker, part, then per-block lock codes (all unlocked)
  assign id_word = flash_addr[1] ? 16'h0000 : (flash_addr[0] ? PART_CODE : MAKER_CODE);
  assign ready_busy_level = (busy_cnt == 0);
  // drive data on a clean read cycle only, else pulled up
  always_comb begin
    if (sel && !output_enable_n && write_enable_n) begin
      if (mode_reg == 8'h70) dq_drive = {8'h00, busy_cnt == 0, 7'h00};
      else if (mode_reg == 8'h90) dq_drive = id_word;
      else dq_drive = width_select ? arr : {8'hFF, arr[7:0]};
    end else dq_drive = 16'hFFFF;
  end
  ////////////////////////////////////////////////////////////////
  // command capture on each rising strobe, abort on reset
  always @(posedge clk or negedge reset_powerdown_n) begin
    if (!reset_powerdown_n) begin
      mode_reg <= 8'hFF;
      prev_reg <= 8'hFF;
      busy_cnt <= 0;
      we_reg   <= 1'b1;
    end else begin
      we_reg <= write_enable_n;
      if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
      if (write_enable_n && !we_reg && sel && output_enable_n) begin
        prev_reg <= dq_bus[7:0];
        if (prev_reg == 8'h20 && dq_bus[7:0] == 8'hD0) busy_cnt <= BUSY_CYC;
        else mode_reg <= dq_bus[7:0];
      end
    end
  end
endmodule : fls_flash_model

// file: verif/fls_host_checker.sv
// checker: pin sequencing assertions for the flash bus host
`timescale 1ns/1ps
module fls_host_checker
  import fls_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic powerdown_req,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic reset_powerdown_n,
  input wire logic dq_oe
);
  int lo_cnt;
  int hi_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // cycles the reset pin has been low, and high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lo_cnt <= 0;
      hi_cnt <= 0;
    end else begin
      lo_cnt <= reset_powerdown_n ? 0 : lo_cnt + 1;
      hi_cnt <= reset_powerdown_n ? hi_cnt + 1 : 0;
    end
  end
  sequence rd_take; req_valid && req_ready && !req_write; endsequence
  sequence wr_take; req_valid && req_ready && req_write; endsequence
  sequence rd_walk; !output_enable_n [*5] ##1 (rsp_valid && output_enable_n); endsequence
  sequence wr_walk;
    (!write_enable_n && !chip_select_a_n) [*3] ##1 (write_enable_n && !chip_select_a_n)
      ##1 (chip_select_a_n && !dq_oe);
  endsequence
  a_oe_we_excl: assert property (output_enable_n || write_enable_n)
    else $error("output and write enable low together");
  a_sel_pair: assert property (chip_select_a_n == chip_select_b_n)
    else $error("chip selects differ");
  a_read_gate: assert property (!output_enable_n |->
    !chip_select_a_n && write_enable_n && reset_powerdown_n && !dq_oe)
    else $error("read enable outside a read cycle");
  a_write_gate: assert property (!write_enable_n |->
    !chip_select_a_n && output_enable_n && reset_powerdown_n && dq_oe)
    else $error("write strobe outside a write cycle");
  a_read_walk: assert property (disable iff (rst || powerdown_req) rd_take |-> ##1 rd_walk)
    else $error("read cycle timing wrong");
  a_write_walk: assert property (disable iff (rst || powerdown_req)
    wr_take |-> ##1 (!chip_select_a_n && dq_oe && write_enable_n) ##1 wr_walk)
    else $error("write strobe not released before select");
  a_reset_pulse: assert property ($rose(reset_powerdown_n) |-> lo_cnt >= RESET_LOW_CYC)
    else $error("reset pulse too short");
  a_wake_wait: assert property (req_ready |-> hi_cnt >= WAKE_CYC - 1)
    else $error("request accepted before recovery");
  a_rst_pd: assert property (disable iff (1'b0) rst |-> !reset_powerdown_n)
    else $error("flash reset not asserted with system reset");
  a_pd_req: assert property ($rose(powerdown_req) |-> ##[1:2] !reset_powerdown_n)
    else $error("power-down not entered");
endmodule : fls_host_checker
bind fls_host fls_host_checker u_fls_host_checker (.clk, .rst, .powerdown_req, .req_valid,
  .req_write, .req_ready, .rsp_valid, .chip_select_a_n, .chip_select_b_n, .output_enable_n,
  .write_enable_n, .reset_powerdown_n, .dq_oe);

// file: verif/fls_host_tb.sv
// testbench: flash bus host against the flash pin model
`timescale 1ns/1ps
module fls_host_tb;
  import fls_pkg::*;
  logic        clk = 1'b0, rst = 1'b0, powerdown_req = 1'b0, wide_mode = 1'b1;
  logic        req_valid = 1'b0, req_write = 1'b0;
  logic [21:0] req_addr = 22'h0, flash_addr, a;
  logic [15:0] req_wdata = 16'h0, rsp_rdata, dq_out, dq_drive, dq_in;
  logic        req_ready, rsp_valid, array_mode, flash_busy, ready_busy_level, dq_oe;
  logic        chip_select_a_n, chip_select_b_n, output_enable_n, write_enable_n;
  logic        reset_powerdown_n, width_select;
  logic [15:0] exp_q[$];
  int          n_errors = 0, check_count = 0;
  localparam logic [15:0] MAKER_EXP = 16'h00C3; // arbitrary identifier value
  localparam logic [15:0] PART_EXP  = 16'h3C11; // arbitrary identifier value
  // shared data wire: host drives on writes, model otherwise
  assign dq_in = dq_oe ? dq_out : dq_drive;
  always #10 clk = ~clk;
  fls_host u_fls_host (.clk, .rst, .powerdown_req, .wide_mode, .req_valid, .req_write,
    .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .array_mode, .flash_busy,
    .chip_select_a_n, .chip_select_b_n, .output_enable_n, .write_enable_n, .reset_powerdown_n,
    .width_select, .flash_addr, .dq_out, .dq_oe, .dq_in, .ready_busy_level);
  fls_flash_model #(.MAKER_CODE(MAKER_EXP), .PART_CODE(PART_EXP)) u_fls_flash_model (
    .clk, .chip_select_a_n, .chip_select_b_n,
    .output_enable_n, .write_enable_n, .reset_powerdown_n, .width_select, .flash_addr,
    .dq_bus(dq_in), .dq_drive, .ready_busy_level);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic req(input logic w, input logic [21:0] ad, input logic [15:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin @(posedge clk); #1; n++; end
    req_valid = 1'b1; req_write = w; req_addr = ad; req_wdata = d;
    @(posedge clk); #1;
    req_valid = 1'b0;
    if (n >= 300) n_errors++;
  endtask : req
  task automatic rd(input logic [21:0] ad, input logic [15:0] e);
    exp_q.push_back(e);
    req(1'b0, ad, 16'h0000);
  endtask : rd
  task automatic settle;
    int n;
    n = 0;
    while ((exp_q.size() != 0 || req_ready !== 1'b1) && n < 300) begin @(posedge clk); #1; n++; end
    if (n >= 300) n_errors++;
  endtask : settle
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // read results against the oldest noted expectation
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("wrong value rsp_valid expected 0 seen 1");
      end else chk("rsp_rdata", exp_q.pop_front(), rsp_rdata);
    end
  end
  // main sequence
  initial begin
    void'($urandom(29));
    #1 rst = 1'b1;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = 22'($urandom);
      rd(a, a[15:0] ^ 16'h5A5A);
    end
    settle;
    chk("array_mode", 16'h1, {15'h0, array_mode});
    $display("test power-up reads done");
    wide_mode = 1'b0;
    a = 22'($urandom);
    rd(a, {8'h00, a[7:0] ^ 8'h5A});
    settle;
    wide_mode = 1'b1;
    $display("test byte mode done");
    req(1'b1, 22'($urandom), 16'h0070);
    rd(22'h0, 16'h0080);
    settle;
    chk("array_mode", 16'h0, {15'h0, array_mode});
    req(1'b1, 22'h0, 16'h00D0);
    settle;
    chk("flash_busy", 16'h0, {15'h0, flash_busy});
    $display("test status and stray confirm done");
    req(1'b1, 22'h0, 16'h0090);
    rd(22'h0, MAKER_EXP);
    rd(22'h1, PART_EXP);
    rd(22'h2, 16'h0000);
    req(1'b1, 22'h0, {8'h00, CMD_READ_ARRAY});
    settle;
    chk("array_mode", 16'h1, {15'h0, array_mode});
    a = 22'($urandom);
    rd(a, a[15:0] ^ 16'h5A5A);
    settle;
    $display("test identifier and array modes done");
    a = 22'($urandom);
    req(1'b1, a, 16'h0020);
    req(1'b1, a, 16'h00D0);
    req(1'b1, a, 16'h0070);
    rd(a, 16'h0000);
    settle;
    chk("flash_busy", 16'h1, {15'h0, flash_busy});
    $display("test two-step erase done");
    powerdown_req = 1'b1;
    repeat (10) @(posedge clk);
    #1 powerdown_req = 1'b0;
    a = 22'($urandom);
    rd(a, a[15:0] ^ 16'h5A5A);
    settle;
    chk("flash_busy", 16'h0, {15'h0, flash_busy});
    chk("array_mode", 16'h1, {15'h0, array_mode});
    $display("test power-down abort done");
    complete_run;
  end
  // watchdog against a hung handshake
  initial begin
    #400000;
    n_errors++;
    complete_run;
  end
endmodule : fls_host_tb
